// ==== rtl/mppd_consts.vh ====
// Constants for the multi-port pin data register block.
// Assumes inclusion by the pin data block files and by the test bench.
`ifndef MPPD_CONSTS_VH
`define MPPD_CONSTS_VH
// ------------------------------------------------------------
// Register byte addresses
// ------------------------------------------------------------
`define MPPD_ADDR_W        32
`define MPPD_OFF_PORT_C    32'h04000124
`define MPPD_OFF_PORT_D    32'h04000126
`define MPPD_OFF_PORT_E    32'h04000128
`define MPPD_OFF_PORT_F    32'h0400012A
`define MPPD_OFF_PORT_G    32'h0400012C
`define MPPD_OFF_PORT_H    32'h0400012E
`define MPPD_OFF_FUNC_C    32'h04000140
`define MPPD_OFF_FUNC_D    32'h04000144
`define MPPD_OFF_FUNC_E    32'h04000148
`define MPPD_OFF_FUNC_F    32'h0400014C
`define MPPD_OFF_FUNC_G    32'h04000150
`define MPPD_OFF_FUNC_H    32'h04000154
// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define MPPD_RST_PORT_C    8'hFF
`define MPPD_RST_PORT_D    8'hFB
`define MPPD_RST_PORT_E    8'hFF
`define MPPD_RST_PORT_H    8'h00
`define MPPD_RST_FUNC      16'hAAAA
// ------------------------------------------------------------
// Writable bit masks
// ------------------------------------------------------------
`define MPPD_WMASK_ALL     8'hFF
`define MPPD_WMASK_PORT_D  8'hAF
`define MPPD_WMASK_PORT_H  8'h80
`define MPPD_WMASK_NONE    8'h00
// ------------------------------------------------------------
// Function codes
// ------------------------------------------------------------
`define MPPD_FN_ALT        2'h0
`define MPPD_FN_OUT        2'h1
`define MPPD_FN_IN_PU      2'h2
`define MPPD_FN_IN_NOPU    2'h3
`define MPPD_ZERO32        32'h00000000
`endif

// ==== rtl/mppd_port.v ====
// One eight-bit port: stored data bits, pin drive and read multiplexing.
// Assumes synchronised pin levels and a function field from the controller.
`timescale 1ns/100ps
`include "mppd_consts.vh"
module mppd_port #(
  parameter [7:0] RST_VAL  = 8'h00,
  parameter [7:0] WMASK    = 8'hFF,
  parameter [7:0] HAS_STORE = 8'hFF
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        clk_en,
  input  wire        wr_en,
  input  wire [7:0]  wr_data,
  input  wire [15:0] func_sel,
  input  wire [7:0]  pin_level,
  output wire [7:0]  rd_data,
  output wire [7:0]  pin_out,
  output wire [7:0]  pin_oe,
  output wire [7:0]  pullup_en
);
  reg  [7:0] data_r;
  reg  [7:0] data_nxt;
  reg  [7:0] rd_c;
  reg  [7:0] oe_c;
  reg  [7:0] pu_c;
  reg  [1:0] fn;
  integer    i;

  always @*
  begin
    data_nxt = (data_r & ~WMASK) | (wr_data & WMASK);
  end

  // Power-on reset only; no other mode touches these bits.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      data_r <= RST_VAL;
    else if (clk_en && wr_en)
      data_r <= data_nxt;
  end

  always @*
  begin
    rd_c = 8'h00;
    oe_c = 8'h00;
    pu_c = 8'h00;
    fn   = 2'h0;
    for (i = 0; i < 8; i = i + 1)
    begin
      fn      = func_sel[2*i +: 2];
      pu_c[i] = (fn == `MPPD_FN_IN_PU);
      if (fn == `MPPD_FN_IN_PU || fn == `MPPD_FN_IN_NOPU)
        rd_c[i] = pin_level[i];
      else if (HAS_STORE[i])
        rd_c[i] = data_r[i];
      else
        rd_c[i] = 1'b0;
      oe_c[i] = HAS_STORE[i] & WMASK[i] & (fn == `MPPD_FN_OUT);
    end
  end

  assign rd_data   = rd_c;
  assign pin_out   = data_r & WMASK;
  assign pin_oe    = oe_c;
  assign pullup_en = pu_c;
endmodule // mppd_port

// ==== rtl/mppd_top.v ====
// Pin data registers for ports C to H with an APB slave.
// Assumes an APB master on pclk; pins arrive asynchronously.
//
// What this block does
// - Each pin's two-bit function field comes from the function controller.
// - Codes: 00 alternate, 01 output, 10 input pull-up, 11 input no pull-up.
// - Output pins read back the stored register bit.
// - Input pins read the live pin level.
// - In output mode a written bit is stored and driven on the pin.
// - In alternate or input modes a write is stored, pin unchanged.
// - Port C input pins read the pin; writes stored without pin effect.
// - Port D has six writable bits; bits 6 and 4 are input only.
// - Port D bits 6 and 4 read low outside input; writes ignored.
// - Power-on reset loads port D with FB.
// - Data registers keep contents except on power-on reset.
// - Data bit n maps to pin n.
// - Port E has eight bidirectional pins.
// - Port F is read-only input; codes 00 and 01 read zero.
// - Port F input modes read the pin levels.
// - Port G is read-only input; non-input codes read zero.
// - Port H has only bit 7 writable and bidirectional.
// - Port H bits 6 to 0 read low outside input; writes ignored.
// - Power-on reset loads port H with zero.
`timescale 1ns/100ps
`include "mppd_consts.vh"
module mppd_top (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        clk_en,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [7:0]  port_c_pin_in,
  input  wire [7:0]  port_d_pin_in,
  input  wire [7:0]  port_e_pin_in,
  input  wire [7:0]  port_f_pin_in,
  input  wire [7:0]  port_g_pin_in,
  input  wire [7:0]  port_h_pin_in,
  output reg  [7:0]  port_c_pin_out,
  output reg  [7:0]  port_c_pin_oe,
  output reg  [7:0]  port_c_pullup,
  output reg  [7:0]  port_d_pin_out,
  output reg  [7:0]  port_d_pin_oe,
  output reg  [7:0]  port_d_pullup,
  output reg  [7:0]  port_e_pin_out,
  output reg  [7:0]  port_e_pin_oe,
  output reg  [7:0]  port_e_pullup,
  output reg  [7:0]  port_f_pullup,
  output reg  [7:0]  port_g_pullup,
  output reg  [7:0]  port_h_pin_out,
  output reg  [7:0]  port_h_pin_oe,
  output reg  [7:0]  port_h_pullup
);
  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  reg  [47:0] pin_meta_r;
  reg  [47:0] pin_sync_r;
  wire [47:0] pin_raw = {port_h_pin_in, port_g_pin_in, port_f_pin_in,
                         port_e_pin_in, port_d_pin_in, port_c_pin_in};

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_meta_r <= 48'h000000000000;
      pin_sync_r <= 48'h000000000000;
    end
    else if (clk_en)
    begin
      pin_meta_r <= pin_raw;
      pin_sync_r <= pin_meta_r;
    end
  end

  // ------------------------------------------------------------
  // Function control registers
  // ------------------------------------------------------------
  reg  [15:0] func_c_r;
  reg  [15:0] func_d_r;
  reg  [15:0] func_e_r;
  reg  [15:0] func_f_r;
  reg  [15:0] func_g_r;
  reg  [15:0] func_h_r;

  // Single-cycle access phase: pready is high whenever the access phase is seen.
  wire wr_acc = psel & penable & pwrite & clk_en;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      func_c_r <= `MPPD_RST_FUNC;
      func_d_r <= `MPPD_RST_FUNC;
      func_e_r <= `MPPD_RST_FUNC;
      func_f_r <= `MPPD_RST_FUNC;
      func_g_r <= `MPPD_RST_FUNC;
      func_h_r <= `MPPD_RST_FUNC;
    end
    else if (wr_acc)
    begin
      if (paddr == `MPPD_OFF_FUNC_C)
        func_c_r <= pwdata[15:0];
      else if (paddr == `MPPD_OFF_FUNC_D)
        func_d_r <= pwdata[15:0];
      else if (paddr == `MPPD_OFF_FUNC_E)
        func_e_r <= pwdata[15:0];
      else if (paddr == `MPPD_OFF_FUNC_F)
        func_f_r <= pwdata[15:0];
      else if (paddr == `MPPD_OFF_FUNC_G)
        func_g_r <= pwdata[15:0];
      else if (paddr == `MPPD_OFF_FUNC_H)
        func_h_r <= pwdata[15:0];
    end
  end

  // ------------------------------------------------------------
  // Ports
  // ------------------------------------------------------------
  wire [7:0] rd_c, rd_d, rd_e, rd_f, rd_g, rd_h;
  wire [7:0] out_c, out_d, out_e, out_h;
  wire [7:0] oe_c, oe_d, oe_e, oe_h;
  wire [7:0] pu_c, pu_d, pu_e, pu_f, pu_g, pu_h;

  // Strobes are decoded once here so each port sees a single-bit enable.
  wire       wr_port_c = wr_acc & (paddr == `MPPD_OFF_PORT_C);
  wire       wr_port_d = wr_acc & (paddr == `MPPD_OFF_PORT_D);
  wire       wr_port_e = wr_acc & (paddr == `MPPD_OFF_PORT_E);
  wire       wr_port_h = wr_acc & (paddr == `MPPD_OFF_PORT_H);

  mppd_port #(
    .RST_VAL   (`MPPD_RST_PORT_C),
    .WMASK     (`MPPD_WMASK_ALL),
    .HAS_STORE (`MPPD_WMASK_ALL)
  ) u_port_c (
    .pclk      (pclk),
    .presetn   (presetn),
    .clk_en    (clk_en),
    .wr_en     (wr_port_c),
    .wr_data   (pwdata[7:0]),
    .func_sel  (func_c_r),
    .pin_level (pin_sync_r[7:0]),
    .rd_data   (rd_c),
    .pin_out   (out_c),
    .pin_oe    (oe_c),
    .pullup_en (pu_c)
  );

  mppd_port #(
    .RST_VAL   (`MPPD_RST_PORT_D),
    .WMASK     (`MPPD_WMASK_PORT_D),
    .HAS_STORE (`MPPD_WMASK_PORT_D)
  ) u_port_d (
    .pclk      (pclk),
    .presetn   (presetn),
    .clk_en    (clk_en),
    .wr_en     (wr_port_d),
    .wr_data   (pwdata[7:0]),
    .func_sel  (func_d_r),
    .pin_level (pin_sync_r[15:8]),
    .rd_data   (rd_d),
    .pin_out   (out_d),
    .pin_oe    (oe_d),
    .pullup_en (pu_d)
  );

  mppd_port #(
    .RST_VAL   (`MPPD_RST_PORT_E),
    .WMASK     (`MPPD_WMASK_ALL),
    .HAS_STORE (`MPPD_WMASK_ALL)
  ) u_port_e (
    .pclk      (pclk),
    .presetn   (presetn),
    .clk_en    (clk_en),
    .wr_en     (wr_port_e),
    .wr_data   (pwdata[7:0]),
    .func_sel  (func_e_r),
    .pin_level (pin_sync_r[23:16]),
    .rd_data   (rd_e),
    .pin_out   (out_e),
    .pin_oe    (oe_e),
    .pullup_en (pu_e)
  );

  mppd_port #(
    .RST_VAL   (`MPPD_WMASK_NONE),
    .WMASK     (`MPPD_WMASK_NONE),
    .HAS_STORE (`MPPD_WMASK_NONE)
  ) u_port_f (
    .pclk      (pclk),
    .presetn   (presetn),
    .clk_en    (clk_en),
    .wr_en     (1'b0),
    .wr_data   (pwdata[7:0]),
    .func_sel  (func_f_r),
    .pin_level (pin_sync_r[31:24]),
    .rd_data   (rd_f),
    .pin_out   (),
    .pin_oe    (),
    .pullup_en (pu_f)
  );

  mppd_port #(
    .RST_VAL   (`MPPD_WMASK_NONE),
    .WMASK     (`MPPD_WMASK_NONE),
    .HAS_STORE (`MPPD_WMASK_NONE)
  ) u_port_g (
    .pclk      (pclk),
    .presetn   (presetn),
    .clk_en    (clk_en),
    .wr_en     (1'b0),
    .wr_data   (pwdata[7:0]),
    .func_sel  (func_g_r),
    .pin_level (pin_sync_r[39:32]),
    .rd_data   (rd_g),
    .pin_out   (),
    .pin_oe    (),
    .pullup_en (pu_g)
  );

  mppd_port #(
    .RST_VAL   (`MPPD_RST_PORT_H),
    .WMASK     (`MPPD_WMASK_PORT_H),
    .HAS_STORE (`MPPD_WMASK_PORT_H)
  ) u_port_h (
    .pclk      (pclk),
    .presetn   (presetn),
    .clk_en    (clk_en),
    .wr_en     (wr_port_h),
    .wr_data   (pwdata[7:0]),
    .func_sel  (func_h_r),
    .pin_level (pin_sync_r[47:40]),
    .rd_data   (rd_h),
    .pin_out   (out_h),
    .pin_oe    (oe_h),
    .pullup_en (pu_h)
  );

  // ------------------------------------------------------------
  // APB read path and response
  // ------------------------------------------------------------
  reg [31:0] rd_mux;
  reg        hit;

  always @*
  begin
    hit    = 1'b1;
    rd_mux = `MPPD_ZERO32;
    if (paddr == `MPPD_OFF_PORT_C)
      rd_mux = {24'h000000, rd_c};
    else if (paddr == `MPPD_OFF_PORT_D)
      rd_mux = {24'h000000, rd_d};
    else if (paddr == `MPPD_OFF_PORT_E)
      rd_mux = {24'h000000, rd_e};
    else if (paddr == `MPPD_OFF_PORT_F)
      rd_mux = {24'h000000, rd_f};
    else if (paddr == `MPPD_OFF_PORT_G)
      rd_mux = {24'h000000, rd_g};
    else if (paddr == `MPPD_OFF_PORT_H)
      rd_mux = {24'h000000, rd_h};
    else if (paddr == `MPPD_OFF_FUNC_C)
      rd_mux = {16'h0000, func_c_r};
    else if (paddr == `MPPD_OFF_FUNC_D)
      rd_mux = {16'h0000, func_d_r};
    else if (paddr == `MPPD_OFF_FUNC_E)
      rd_mux = {16'h0000, func_e_r};
    else if (paddr == `MPPD_OFF_FUNC_F)
      rd_mux = {16'h0000, func_f_r};
    else if (paddr == `MPPD_OFF_FUNC_G)
      rd_mux = {16'h0000, func_g_r};
    else if (paddr == `MPPD_OFF_FUNC_H)
      rd_mux = {16'h0000, func_h_r};
    else
      hit = 1'b0;
  end

  // The answer is registered in the setup cycle so every bus output
  // comes from a flip-flop; the access phase then completes in one cycle.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= `MPPD_ZERO32;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else if (clk_en)
    begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~hit;
      // An unmapped write also loads rd_mux, which is zero then, so an
      // error answer never carries stale read data.
      if (psel && !penable && (!pwrite || !hit))
        prdata <= rd_mux;
    end
  end

  // ------------------------------------------------------------
  // Registered pin outputs
  // ------------------------------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      port_c_pin_out <= 8'h00;
      port_c_pin_oe  <= 8'h00;
      port_c_pullup  <= 8'h00;
      port_d_pin_out <= 8'h00;
      port_d_pin_oe  <= 8'h00;
      port_d_pullup  <= 8'h00;
      port_e_pin_out <= 8'h00;
      port_e_pin_oe  <= 8'h00;
      port_e_pullup  <= 8'h00;
      port_f_pullup  <= 8'h00;
      port_g_pullup  <= 8'h00;
      port_h_pin_out <= 8'h00;
      port_h_pin_oe  <= 8'h00;
      port_h_pullup  <= 8'h00;
    end
    else if (clk_en)
    begin
      port_c_pin_out <= out_c;
      port_c_pin_oe  <= oe_c;
      port_c_pullup  <= pu_c;
      port_d_pin_out <= out_d;
      port_d_pin_oe  <= oe_d;
      port_d_pullup  <= pu_d;
      port_e_pin_out <= out_e;
      port_e_pin_oe  <= oe_e;
      port_e_pullup  <= pu_e;
      port_f_pullup  <= pu_f;
      port_g_pullup  <= pu_g;
      port_h_pin_out <= out_h;
      port_h_pin_oe  <= oe_h;
      port_h_pullup  <= pu_h;
    end
  end
endmodule // mppd_top

// ==== tb/mppd_monitor.sv ====
// Concurrent checks on the pin data block's bus answer and pin drive.
// Assumes binding to mppd_top, one pclk domain, clk_en held high.
`timescale 1ns/100ps
module mppd_monitor (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [7:0]  port_d_pin_out,
  input wire logic [7:0]  port_d_pin_oe,
  input wire logic [7:0]  port_e_pin_out,
  input wire logic [7:0]  port_e_pin_oe,
  input wire logic [7:0]  port_e_pullup,
  input wire logic [7:0]  port_h_pin_out,
  input wire logic [7:0]  port_h_pin_oe
);
  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_answer; psel && !penable |=> pready; endproperty
  a_answer: assert property (p_answer)
    else $error("No answer one cycle after setup.");
  property p_one; pready |-> psel && penable ##1 !pready; endproperty
  a_one: assert property (p_one)
    else $error("Answer outside a single access cycle.");
  property p_err; pslverr |-> pready && prdata == 32'h00000000; endproperty
  a_err: assert property (p_err)
    else $error("Error answer without ready or with data.");
  property p_d_ro; ((port_d_pin_oe | port_d_pin_out) & 8'h50) == 8'h00; endproperty
  a_d_ro: assert property (p_d_ro)
    else $error("Port D input-only bit driven.");
  property p_h_ro; ((port_h_pin_oe | port_h_pin_out) & 8'h7F) == 8'h00; endproperty
  a_h_ro: assert property (p_h_ro)
    else $error("Port H input-only bit driven.");
  property p_excl; (port_e_pullup & port_e_pin_oe) == 8'h00; endproperty
  a_excl: assert property (p_excl)
    else $error("Pull-up and drive both on.");
  // Past guards skip the update that follows every reset release.
  property p_out_cause;
    $changed(port_e_pin_out) && $past(presetn) && $past(presetn, 2)
      |-> $past(psel && penable && pwrite, 2);
  endproperty
  a_out_cause: assert property (p_out_cause)
    else $error("Pin data changed without a write.");
  property p_pu_cause;
    $changed(port_e_pullup) && $past(presetn) && $past(presetn, 2)
      |-> $past(psel && penable && pwrite, 2);
  endproperty
  a_pu_cause: assert property (p_pu_cause)
    else $error("Pull-up changed without a write.");
endmodule // mppd_monitor

bind mppd_top mppd_monitor i_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .port_d_pin_out(port_d_pin_out), .port_d_pin_oe(port_d_pin_oe),
  .port_e_pin_out(port_e_pin_out), .port_e_pin_oe(port_e_pin_oe),
  .port_e_pullup(port_e_pullup), .port_h_pin_out(port_h_pin_out),
  .port_h_pin_oe(port_h_pin_oe));

// ==== tb/mppd_board.sv ====
// Board-side model of one eight-pin port.
// Assumes the board drives every pin that the block does not drive.
`timescale 1ns/100ps
module mppd_board (
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] drive,
  output wire logic [7:0] pin_in
);
  // Bit n of every bus meets pin n; the block wins only where it drives.
  assign pin_in = (pin_out & pin_oe) | (drive & ~pin_oe);
endmodule // mppd_board

// ==== tb/tb_top.sv ====
// Self-checking bench for the pin data block over APB.
// Assumes the board model and the checker are compiled beforehand.
`timescale 1ns/100ps
`include "mppd_consts.vh"
module tb_top;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [31:0] paddr = 0, pwdata = 0;
  wire  [31:0] prdata;
  wire         pready, pslverr;
  logic [7:0]  ext [0:5], st [0:5], wm [0:5];
  logic [15:0] fn [0:5];
  logic [23:0] expq [$], e;
  wire  [7:0]  pin [0:5], pout [0:5], poe [0:5], pu [0:5];
  integer      fails = 0, n_tests = 0, seed = 67721, i, r;
  logic [31:0] k;
  always #2 pclk = ~pclk;
  assign pout[3] = 8'h00;
  assign pout[4] = 8'h00;
  assign poe[3] = 8'h00;
  assign poe[4] = 8'h00;
  for (genvar g = 0; g < 6; g++)
    mppd_board i_brd (.pin_out(pout[g]), .pin_oe(poe[g]), .drive(ext[g]), .pin_in(pin[g]));
  mppd_top i_dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .port_c_pin_in(pin[0]), .port_d_pin_in(pin[1]),
    .port_e_pin_in(pin[2]), .port_f_pin_in(pin[3]), .port_g_pin_in(pin[4]),
    .port_h_pin_in(pin[5]), .port_c_pin_out(pout[0]), .port_c_pin_oe(poe[0]),
    .port_c_pullup(pu[0]), .port_d_pin_out(pout[1]), .port_d_pin_oe(poe[1]),
    .port_d_pullup(pu[1]), .port_e_pin_out(pout[2]), .port_e_pin_oe(poe[2]),
    .port_e_pullup(pu[2]), .port_f_pullup(pu[3]), .port_g_pullup(pu[4]),
    .port_h_pin_out(pout[5]), .port_h_pin_oe(poe[5]), .port_h_pullup(pu[5]));
  // ----------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------
  task automatic conclude;
    if (fails == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic init;
    st = '{`MPPD_RST_PORT_C, `MPPD_RST_PORT_D, `MPPD_RST_PORT_E, 8'h00, 8'h00,
           `MPPD_RST_PORT_H};
  endtask
  // Reads follow the function code: input codes see the pin, others the store.
  function automatic logic [23:0] exp_f(input integer p);
    logic [1:0] c;
    for (int b = 0; b < 8; b++)
    begin
      c = fn[p][2*b +: 2];
      exp_f[b] = c[1] ? ext[p][b] : st[p][b] & wm[p][b];
      exp_f[8+b] = (c == `MPPD_FN_IN_PU);
      exp_f[16+b] = (c == `MPPD_FN_OUT) & wm[p][b];
    end
  endfunction
  // ----------------------------------------------------------
  // Scoreboard and sequence
  // ----------------------------------------------------------
  always @(posedge pclk)
    if (psel && penable && pready && !pwrite)
      check({15'h0, pslverr, prdata[7:0]}, expq.pop_front());
  initial
  begin
    #200000;
    fails++;
    conclude;
  end
  initial
  begin
    for (i = 0; i < 6; i++) ext[i] = 8'h00;
    wm = '{`MPPD_WMASK_ALL, `MPPD_WMASK_PORT_D, `MPPD_WMASK_ALL, `MPPD_WMASK_NONE,
           `MPPD_WMASK_NONE, `MPPD_WMASK_PORT_H};
    init;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (r = 0; r < 60; r++)
    begin
      // Rounds 0 and 30 keep the store untouched to expose reset values.
      for (i = 0; i < 6; i++)
      begin
        ext[i] <= $random(seed);
        fn[i] = (r % 30) ? $random(seed) : 16'h5555;
        apb(1'b1, `MPPD_OFF_FUNC_C + 4 * i, {16'h0000, fn[i]});
        k = $random(seed);
        if (r % 30) apb(1'b1, `MPPD_OFF_PORT_C + 2 * i, k);
        if (r % 30) st[i] = (st[i] & ~wm[i]) | (k[7:0] & wm[i]);
      end
      repeat (4) @(posedge pclk);
      for (i = 0; i < 6; i++)
      begin
        e = exp_f(i);
        check({poe[i], pu[i], pout[i]}, {e[23:8], st[i] & wm[i]});
        expq.push_back({16'h0000, e[7:0]});
        apb(1'b0, `MPPD_OFF_PORT_C + 2 * i, 32'h00000000);
      end
      expq.push_back(24'h000100);
      apb(1'b0, 32'h04000122, 32'h00000000);
      apb(1'b1, 32'h04000122, $random(seed));
      if (r == 29)
      begin
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        init;
        @(posedge pclk);
      end
    end
    conclude;
  end
endmodule // tb_top
